// *** logic/dxf_regs.sv ***
`timescale 1ns/1ps
// Behaviour
// - The options word holds the clock-source selection.
// - Options and settings go out per line beside the index.
// - Settings are copied into the feature as it starts.
// - Updatable features take new settings while running.
// - Index and options are locked while the line runs.
// - Two integer result words per line, for lines 0 to 21, are read-only.
// - Converted results sit in separate read-only words.
// - The integer clear word returns result A and a reset if the line runs.
// - The real clear word returns real result A and a reset if the line runs.
// - A reset clears a counting feature, which keeps running.
// - Command reads always work; stream needs a streamable feature.
// - Stream integer reads give the low half, capture the high.
// - Line-to-line and quadrature also claim the next line.
// - Each line has a run switch; results read while stopped.
// - Indices 0 to 12 are decoded; larger ones are refused.
module dxf_regs (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic stream_mode,
    input wire dxf_pkg::dxf_words_t int_result_a_in,
    input wire dxf_pkg::dxf_words_t int_result_b_in,
    input wire dxf_pkg::dxf_words_t real_result_a_in,
    input wire dxf_pkg::dxf_words_t real_result_b_in,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    output logic [15:0] capture_hi,
    output logic [dxf_pkg::NUM_LINES-1:0] line_run,
    output logic [dxf_pkg::NUM_LINES-1:0][3:0] line_index,
    output dxf_pkg::dxf_words_t line_options,
    output dxf_pkg::dxf_words_t line_setting_a,
    output dxf_pkg::dxf_words_t line_setting_b,
    output dxf_pkg::dxf_words_t line_setting_c,
    output dxf_pkg::dxf_words_t line_setting_d,
    output logic [dxf_pkg::NUM_LINES-1:0] line_feature_reset
);

    // ------------
    // decode helpers
    // ------------

    // hit flag in bit 5, line number in bits 4:0
    function automatic logic [5:0] word_hit(input logic [15:0] addr, input logic [15:0] base,
                                            input logic [4:0] lines);
        logic [15:0] delta;
        logic [5:0] res;
        delta = addr - base;
        res = 6'h00;
        if (addr >= base && !delta[0] && delta[15:1] < {10'h000, lines}) begin
            res = {1'b1, delta[5:1]};
        end
        return res;
    endfunction

    // features allowed in stream reads
    function automatic logic streamable(input logic [3:0] idx);
        return idx inside {dxf_pkg::FEAT_FREQ_IN_A, dxf_pkg::FEAT_FREQ_IN_B,
                           dxf_pkg::FEAT_PULSE_WIDTH, dxf_pkg::FEAT_HS_COUNTER,
                           dxf_pkg::FEAT_INT_COUNTER, dxf_pkg::FEAT_DEB_COUNTER,
                           dxf_pkg::FEAT_QUADRATURE, dxf_pkg::FEAT_INT_FREQ};
    endfunction

    // features whose setting words follow writes while running
    function automatic logic updatable(input logic [3:0] idx);
        return idx inside {dxf_pkg::FEAT_PWM, dxf_pkg::FEAT_PWM_PHASE,
                           dxf_pkg::FEAT_PULSE_OUT, dxf_pkg::FEAT_COND_RESET};
    endfunction

    // features that take the next line as well
    function automatic logic two_line(input logic [3:0] idx);
        return idx == dxf_pkg::FEAT_LINE_TO_LINE || idx == dxf_pkg::FEAT_QUADRATURE;
    endfunction

    // ------------
    // state
    // ------------

    dxf_pkg::dxf_state_t s_r;
    dxf_pkg::dxf_state_t s_nxt;

    // partner of a line is the next one up; the top line has none
    logic [dxf_pkg::NUM_LINES-1:0] partner_busy;
    logic [dxf_pkg::NUM_LINES-1:0] claimed_below;

    // neighbour occupancy per line
    for (genvar g = 0; g < dxf_pkg::NUM_LINES; g++) begin : g_pair
        if (g == dxf_pkg::NUM_LINES - 1) begin : g_top
            assign partner_busy[g] = 1'b1;
        end else begin : g_mid
            assign partner_busy[g] = s_r.run[g+1];
        end
        if (g == 0) begin : g_bot
            assign claimed_below[g] = 1'b0;
        end else begin : g_up
            assign claimed_below[g] = s_r.run[g-1] && two_line(s_r.index[g-1]);
        end
    end

    // next-state logic for all registers and the read answer
    always_comb begin
        logic [5:0] h_ia;
        logic [5:0] h_iac;
        logic [5:0] h_ib;
        logic [5:0] h_ra;
        logic [5:0] h_rac;
        logic [5:0] h_rb;
        logic [5:0] h_run;
        logic [5:0] h_idx;
        logic [5:0] h_opt;
        logic [5:0] h_sa;
        logic [5:0] h_sb;
        logic [5:0] h_sc;
        logic [5:0] h_sd;
        logic [4:0] ln;
        logic [31:0] rword;
        logic int_word;
        logic clr;
        h_ia = word_hit(reg_addr, dxf_pkg::ADDR_INT_RESULT_A, dxf_pkg::RESULT_LINES);
        h_iac = word_hit(reg_addr, dxf_pkg::ADDR_INT_RESULT_A_CLEAR, dxf_pkg::RESULT_LINES);
        h_ib = word_hit(reg_addr, dxf_pkg::ADDR_INT_RESULT_B, dxf_pkg::RESULT_LINES);
        h_ra = word_hit(reg_addr, dxf_pkg::ADDR_REAL_RESULT_A, dxf_pkg::RESULT_LINES);
        h_rac = word_hit(reg_addr, dxf_pkg::ADDR_REAL_RESULT_A_CLEAR, dxf_pkg::RESULT_LINES);
        h_rb = word_hit(reg_addr, dxf_pkg::ADDR_REAL_RESULT_B, dxf_pkg::RESULT_LINES);
        h_run = word_hit(reg_addr, dxf_pkg::ADDR_RUN_SWITCH, dxf_pkg::CONFIG_LINES);
        h_idx = word_hit(reg_addr, dxf_pkg::ADDR_SELECT_INDEX, dxf_pkg::CONFIG_LINES);
        h_opt = word_hit(reg_addr, dxf_pkg::ADDR_OPTIONS, dxf_pkg::CONFIG_LINES);
        h_sa = word_hit(reg_addr, dxf_pkg::ADDR_SETTING_A, dxf_pkg::CONFIG_LINES);
        h_sb = word_hit(reg_addr, dxf_pkg::ADDR_SETTING_B, dxf_pkg::CONFIG_LINES);
        h_sc = word_hit(reg_addr, dxf_pkg::ADDR_SETTING_C, dxf_pkg::CONFIG_LINES);
        h_sd = word_hit(reg_addr, dxf_pkg::ADDR_SETTING_D, dxf_pkg::CONFIG_LINES);
        ln = reg_addr[5:1];
        rword = dxf_pkg::WORD_RESET;
        int_word = 1'b0;
        clr = 1'b0;

        s_nxt = s_r;
        s_nxt.feat_reset = '0;
        s_nxt.rvalid = 1'b0;
        s_nxt.err = 1'b0;

        if (reg_wr) begin
            // write side, one register per request
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = dxf_pkg::WORD_RESET;
            if (h_run[5]) begin
                ln = h_run[4:0];
                if (!reg_wdata[dxf_pkg::RUN_BIT]) begin
                    s_nxt.run[ln] = 1'b0;
                end else if (!s_r.run[ln]) begin
                    if (!dxf_pkg::LINE_CAPABLE[ln][s_r.index[ln]] || claimed_below[ln]
                        || (two_line(s_r.index[ln]) && partner_busy[ln])) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.run[ln] = 1'b1;
                        s_nxt.act_a[ln] = s_r.set_a[ln];
                        s_nxt.act_b[ln] = s_r.set_b[ln];
                        s_nxt.act_c[ln] = s_r.set_c[ln];
                        s_nxt.act_d[ln] = s_r.set_d[ln];
                    end
                end
            end else if (h_idx[5]) begin
                ln = h_idx[4:0];
                if (s_r.run[ln] || reg_wdata > {28'h0000000, dxf_pkg::INDEX_MAX}) begin
                    s_nxt.err = 1'b1;
                end else begin
                    s_nxt.index[ln] = reg_wdata[3:0];
                end
            end else if (h_opt[5]) begin
                ln = h_opt[4:0];
                if (s_r.run[ln]) begin
                    s_nxt.err = 1'b1;
                end else begin
                    s_nxt.options[ln] = reg_wdata;
                end
            end else if (h_sa[5] || h_sb[5] || h_sc[5] || h_sd[5]) begin
                ln = h_sa[5] ? h_sa[4:0] : h_sb[5] ? h_sb[4:0] : h_sc[5] ? h_sc[4:0] : h_sd[4:0];
                if (h_sa[5]) s_nxt.set_a[ln] = reg_wdata;
                if (h_sb[5]) s_nxt.set_b[ln] = reg_wdata;
                if (h_sc[5]) s_nxt.set_c[ln] = reg_wdata;
                if (h_sd[5]) s_nxt.set_d[ln] = reg_wdata;
                if (s_r.run[ln] && updatable(s_r.index[ln])) begin
                    if (h_sa[5]) s_nxt.act_a[ln] = reg_wdata;
                    if (h_sb[5]) s_nxt.act_b[ln] = reg_wdata;
                    if (h_sc[5]) s_nxt.act_c[ln] = reg_wdata;
                    if (h_sd[5]) s_nxt.act_d[ln] = reg_wdata;
                end
            end else begin
                s_nxt.err = 1'b1; // unmapped or read-only word
            end
        end else if (reg_rd) begin
            s_nxt.rvalid = 1'b1;
            if (h_ia[5]) begin
                ln = h_ia[4:0];
                rword = int_result_a_in[ln];
                int_word = 1'b1;
            end else if (h_iac[5]) begin
                ln = h_iac[4:0];
                rword = int_result_a_in[ln];
                int_word = 1'b1;
                clr = 1'b1;
            end else if (h_ib[5]) begin
                ln = h_ib[4:0];
                rword = int_result_b_in[ln];
                int_word = 1'b1;
            end else if (h_ra[5]) begin
                ln = h_ra[4:0];
                rword = real_result_a_in[ln];
            end else if (h_rac[5]) begin
                ln = h_rac[4:0];
                rword = real_result_a_in[ln];
                clr = 1'b1;
            end else if (h_rb[5]) begin
                ln = h_rb[4:0];
                rword = real_result_b_in[ln];
            end else if (h_run[5]) begin
                rword = {31'h00000000, s_r.run[h_run[4:0]]};
            end else if (h_idx[5]) begin
                rword = {28'h0000000, s_r.index[h_idx[4:0]]};
            end else if (h_opt[5]) begin
                rword = s_r.options[h_opt[4:0]];
            end else if (h_sa[5]) begin
                rword = s_r.set_a[h_sa[4:0]];
            end else if (h_sb[5]) begin
                rword = s_r.set_b[h_sb[4:0]];
            end else if (h_sc[5]) begin
                rword = s_r.set_c[h_sc[4:0]];
            end else if (h_sd[5]) begin
                rword = s_r.set_d[h_sd[4:0]];
            end else begin
                s_nxt.err = 1'b1;
            end

            // stream reads limited to streamable features
            if (stream_mode && (h_ia[5] || h_iac[5] || h_ib[5] || h_ra[5] || h_rac[5]
                || h_rb[5]) && (!streamable(s_r.index[ln]) || !int_word)) begin
                s_nxt.err = 1'b1;
                s_nxt.rdata = dxf_pkg::WORD_RESET;
            end else if (stream_mode && int_word) begin
                // low half answered, high half captured
                s_nxt.rdata = {16'h0000, rword[dxf_pkg::STREAM_LO_W-1:0]};
                s_nxt.capture_hi = rword[31:dxf_pkg::STREAM_LO_W];
                // reset pulse only on a running line
                s_nxt.feat_reset[ln] = clr && s_r.run[ln];
            end else begin
                s_nxt.rdata = rword;
                // reset pulse only on a running line
                s_nxt.feat_reset[ln] = clr && s_r.run[ln];
            end
        end
    end

    // ------------
    // registers and outputs
    // ------------

    // single state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state flops
    assign reg_rdata = s_r.rdata;
    assign reg_rvalid = s_r.rvalid;
    assign reg_err = s_r.err;
    assign capture_hi = s_r.capture_hi;
    assign line_run = s_r.run;
    assign line_index = s_r.index;
    // per-line words follow the selected index downstream
    assign line_options = s_r.options;
    assign line_setting_a = s_r.act_a;
    assign line_setting_b = s_r.act_b;
    assign line_setting_c = s_r.act_c;
    assign line_setting_d = s_r.act_d;
    assign line_feature_reset = s_r.feat_reset;

endmodule

// *** logic/dxf_pkg.sv ***
// ------------
// extended line feature register bank constants
// ------------
package dxf_pkg;

    localparam int NUM_LINES = 23;
    localparam int ADDR_W = 16;
    localparam int LINE_W = 5;
    localparam int IDX_W = 4;

    // word start addresses, a 32-bit word spans two addresses
    localparam logic [15:0] ADDR_INT_RESULT_A = 16'h0BB8;
    localparam logic [15:0] ADDR_INT_RESULT_A_CLEAR = 16'h0C1C;
    localparam logic [15:0] ADDR_INT_RESULT_B = 16'h0C80;
    localparam logic [15:0] ADDR_REAL_RESULT_A = 16'h0DAC;
    localparam logic [15:0] ADDR_REAL_RESULT_A_CLEAR = 16'h0E10;
    localparam logic [15:0] ADDR_REAL_RESULT_B = 16'h0E74;
    localparam logic [15:0] ADDR_RUN_SWITCH = 16'hABE0;
    localparam logic [15:0] ADDR_SELECT_INDEX = 16'hAC44;
    localparam logic [15:0] ADDR_OPTIONS = 16'hACA8;
    localparam logic [15:0] ADDR_SETTING_A = 16'hAD0C;
    localparam logic [15:0] ADDR_SETTING_B = 16'hAD70;
    localparam logic [15:0] ADDR_SETTING_C = 16'hADD4;
    localparam logic [15:0] ADDR_SETTING_D = 16'hAE38;
    localparam logic [4:0] RESULT_LINES = 5'h16;
    localparam logic [4:0] CONFIG_LINES = 5'h17;

    // field positions and reset values
    localparam int RUN_BIT = 0;
    localparam int STREAM_LO_W = 16;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [3:0] INDEX_RESET = 4'h0;
    localparam logic [3:0] INDEX_MAX = 4'hC;

    // feature index encodings
    localparam logic [3:0] FEAT_PWM = 4'h0;
    localparam logic [3:0] FEAT_PWM_PHASE = 4'h1;
    localparam logic [3:0] FEAT_PULSE_OUT = 4'h2;
    localparam logic [3:0] FEAT_FREQ_IN_A = 4'h3;
    localparam logic [3:0] FEAT_FREQ_IN_B = 4'h4;
    localparam logic [3:0] FEAT_PULSE_WIDTH = 4'h5;
    localparam logic [3:0] FEAT_LINE_TO_LINE = 4'h6;
    localparam logic [3:0] FEAT_HS_COUNTER = 4'h7;
    localparam logic [3:0] FEAT_INT_COUNTER = 4'h8;
    localparam logic [3:0] FEAT_DEB_COUNTER = 4'h9;
    localparam logic [3:0] FEAT_QUADRATURE = 4'hA;
    localparam logic [3:0] FEAT_INT_FREQ = 4'hB;
    localparam logic [3:0] FEAT_COND_RESET = 4'hC;

    // per-line masks, bit n set when index n is allowed
    localparam logic [NUM_LINES-1:0][12:0] LINE_CAPABLE = {
        13'h0000, 13'h0000, 13'h0000,
        13'h0080, 13'h0080, 13'h0080, 13'h0080,
        13'h0000, 13'h0000, 13'h0000, 13'h0000,
        13'h0000, 13'h0000, 13'h0000, 13'h0000,
        13'h1F00, 13'h1F00, 13'h0007, 13'h0007,
        13'h1F07, 13'h1F07, 13'h1F78, 13'h1F7F
    };

    typedef logic [NUM_LINES-1:0][31:0] dxf_words_t;

    typedef struct packed {
        logic [NUM_LINES-1:0] run;
        logic [NUM_LINES-1:0][3:0] index;
        dxf_words_t options;
        dxf_words_t set_a;
        dxf_words_t set_b;
        dxf_words_t set_c;
        dxf_words_t set_d;
        dxf_words_t act_a;
        dxf_words_t act_b;
        dxf_words_t act_c;
        dxf_words_t act_d;
        logic [NUM_LINES-1:0] feat_reset;
        logic [31:0] rdata;
        logic rvalid;
        logic err;
        logic [15:0] capture_hi;
    } dxf_state_t;

endpackage

// *** testbench/dxf_regs_assertions.sv ***
`timescale 1ns/1ps
module dxf_regs_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic stream_mode,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_err,
    input wire logic [dxf_pkg::NUM_LINES-1:0] line_run,
    input wire logic [dxf_pkg::NUM_LINES-1:0][3:0] line_index,
    input wire dxf_pkg::dxf_words_t line_options,
    input wire logic [dxf_pkg::NUM_LINES-1:0] line_feature_reset
);
    // ------------
    // helper masks
    // ------------
    logic [dxf_pkg::NUM_LINES-1:0] cap_ok, claim;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // capable index and two-line claim per line
    always_comb begin
        for (int i = 0; i < dxf_pkg::NUM_LINES; i++) begin
            cap_ok[i] = line_index[i] <= 4'hC && dxf_pkg::LINE_CAPABLE[i][line_index[i]];
            claim[i] = line_run[i] && (line_index[i] == 4'h6 || line_index[i] == 4'hA);
        end
    end
    // lines whose index or options moved
    function automatic logic [dxf_pkg::NUM_LINES-1:0] moved(
        input logic [dxf_pkg::NUM_LINES-1:0][3:0] i0,
        input logic [dxf_pkg::NUM_LINES-1:0][3:0] i1,
        input dxf_pkg::dxf_words_t o0,
        input dxf_pkg::dxf_words_t o1);
        for (int i = 0; i < dxf_pkg::NUM_LINES; i++) begin
            moved[i] = i0[i] != i1[i] || o0[i] != o1[i];
        end
    endfunction
    // ------------
    // properties
    // ------------
    a_answer_next_cycle: assert property ((reg_wr || reg_rd) |=> reg_rvalid)
        else $error("request not answered next cycle");
    a_no_stray_answer: assert property (!(reg_wr || reg_rd) |=> !reg_rvalid && !reg_err)
        else $error("answer without request");
    a_result_wr_refused: assert property (
        reg_wr && reg_addr >= 16'h0BB8 && reg_addr <= 16'h0E9F |=> reg_err)
        else $error("write to result word accepted");
    a_stream_high_zero: assert property (
        reg_rd && !reg_wr && stream_mode |=> reg_rdata[31:16] == 16'h0000)
        else $error("stream read returned upper half");
    a_stream_float_refused: assert property (reg_rd && !reg_wr && stream_mode
        && reg_addr >= 16'h0DAC && reg_addr <= 16'h0E9F |=> reg_err)
        else $error("stream read of real word accepted");
    a_reset_from_read: assert property (
        |line_feature_reset |-> $past(reg_rd) && !$past(reg_wr))
        else $error("feature reset without a read");
    a_reset_running_only: assert property (
        (line_feature_reset & ~$past(line_run)) == '0)
        else $error("feature reset on a stopped line");
    a_run_capable: assert property ((line_run & ~cap_ok) == '0)
        else $error("line runs an index it cannot carry");
    a_pair_exclusive: assert property (
        (line_run[dxf_pkg::NUM_LINES-1:1] & claim[dxf_pkg::NUM_LINES-2:0]) == '0)
        else $error("neighbour of a two-line feature runs");
    a_locked_while_run: assert property ((line_run & $past(line_run) & moved(line_index,
        $past(line_index), line_options, $past(line_options))) == '0)
        else $error("index or options changed while running");
    a_bad_index_refused: assert property (reg_wr && reg_addr >= 16'hAC44
        && reg_addr < 16'hAC72 && !reg_addr[0] && reg_wdata > 32'h0000_000C |=> reg_err)
        else $error("index above range accepted");
    c_feature_reset: cover property (|line_feature_reset);
    c_stream_read: cover property (reg_rd && stream_mode ##1 reg_rvalid);
    c_refused_write: cover property (reg_wr ##1 reg_err);
endmodule
bind dxf_regs dxf_regs_chk u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .stream_mode(stream_mode),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err), .line_run(line_run),
    .line_index(line_index), .line_options(line_options),
    .line_feature_reset(line_feature_reset));

// *** testbench/dxf_engine_model.sv ***
`timescale 1ns/1ps
module dxf_engine_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [dxf_pkg::NUM_LINES-1:0] line_run,
    input wire logic [dxf_pkg::NUM_LINES-1:0] line_feature_reset,
    output dxf_pkg::dxf_words_t int_result_a,
    output dxf_pkg::dxf_words_t int_result_b,
    output dxf_pkg::dxf_words_t real_result_a,
    output dxf_pkg::dxf_words_t real_result_b
);
    typedef struct packed {
        dxf_pkg::dxf_words_t cnt;
    } dxf_eng_state_t;
    dxf_eng_state_t state_r;
    dxf_eng_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        for (int i = 0; i < dxf_pkg::NUM_LINES; i++) begin
            if (line_feature_reset[i]) begin
                state_nxt.cnt[i] = 32'h0000_0000;
            end else if (line_run[i]) begin
                state_nxt.cnt[i] = state_r.cnt[i] + 32'h0000_0001;
            end
        end
    end
    // counters start with a non-zero upper half
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < dxf_pkg::NUM_LINES; i++) begin
                state_r.cnt[i] <= 32'h0003_0000 + 32'(i);
            end
        end else begin
            state_r <= state_nxt;
        end
    end
    always_comb begin
        for (int i = 0; i < dxf_pkg::NUM_LINES; i++) begin
            int_result_a[i] = state_r.cnt[i];
            int_result_b[i] = 32'hB000_0000 | 32'(i);
            real_result_a[i] = state_r.cnt[i] ^ 32'h4000_0000;
            real_result_b[i] = 32'h4100_0000 | 32'(i);
        end
    end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic clk, reset_n, reg_wr, reg_rd, stream_mode, reg_rvalid, reg_err, got_e;
    logic [15:0] reg_addr, capture_hi;
    logic [31:0] reg_wdata, reg_rdata, got_d;
    logic [dxf_pkg::NUM_LINES-1:0] line_run, frst, got_r;
    logic [dxf_pkg::NUM_LINES-1:0][3:0] line_index;
    dxf_pkg::dxf_words_t ia, ib, ra, rb, line_options, sa, sb, sc, sd, snap_a, snap_r;
    int n_fail = 0;
    int tests_run = 0;
    dxf_regs dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .stream_mode(stream_mode),
        .int_result_a_in(ia), .int_result_b_in(ib), .real_result_a_in(ra),
        .real_result_b_in(rb), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_err(reg_err), .capture_hi(capture_hi), .line_run(line_run),
        .line_index(line_index), .line_options(line_options), .line_setting_a(sa),
        .line_setting_b(sb), .line_setting_c(sc), .line_setting_d(sd),
        .line_feature_reset(frst));
    dxf_engine_model eng (.clk(clk), .reset_n(reset_n), .line_run(line_run),
        .line_feature_reset(frst), .int_result_a(ia), .int_result_b(ib),
        .real_result_a(ra), .real_result_b(rb));
    // ------------
    // bus access and comparison
    // ------------
    task automatic check(input string s, input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // one request, answer read just after the taking edge
    task automatic acc(input logic w, input logic [15:0] b, input int n, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= b + 16'(2 * n);
        reg_wdata <= d;
        #1;
        snap_a = ia;
        snap_r = ra;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        got_d = reg_rdata;
        got_e = reg_err;
        got_r = frst;
        check("answer", 32'(reg_rvalid), 32'h1);
    endtask
    task automatic conclude();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------
    // scenarios
    // ------------
    task automatic t_regs();
        logic [15:0] bs [5];
        bs = '{dxf_pkg::ADDR_OPTIONS, dxf_pkg::ADDR_SETTING_A, dxf_pkg::ADDR_SETTING_B,
            dxf_pkg::ADDR_SETTING_C, dxf_pkg::ADDR_SETTING_D};
        for (int k = 0; k < 5; k++) begin
            acc(0, bs[k], 3, 0);
            check("reset word", got_d, dxf_pkg::WORD_RESET);
            acc(1, bs[k], 3, 32'hC0DE_0000 + 32'(k));
            acc(0, bs[k], 3, 0);
            check("readback", got_d, 32'hC0DE_0000 + 32'(k));
        end
        check("options out", line_options[3], 32'hC0DE_0000);
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 3, 1);
        check("latched c", sc[3], 32'hC0DE_0003);
        check("latched d", sd[3], 32'hC0DE_0004);
        acc(0, dxf_pkg::ADDR_SETTING_A + 16'h0001, 0, 0);
        check("odd err", 32'(got_e), 32'h1);
        acc(1, dxf_pkg::ADDR_INT_RESULT_A, 0, 1);
        check("result wr err", 32'(got_e), 32'h1);
        $display("t_regs done");
    endtask
    task automatic t_latch();
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 2, 0);
        acc(1, dxf_pkg::ADDR_SELECT_INDEX, 2, 32'(dxf_pkg::FEAT_PWM));
        acc(1, dxf_pkg::ADDR_OPTIONS, 2, 1);
        acc(1, dxf_pkg::ADDR_SETTING_A, 2, 32'h1111);
        check("idle a", sa[2], 32'h0);
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 2, 1);
        check("run", 32'(line_run[2]), 32'h1);
        check("latched a", sa[2], 32'h1111);
        acc(1, dxf_pkg::ADDR_SETTING_A, 2, 32'h2222);
        check("live a", sa[2], 32'h2222);
        check("still run", 32'(line_run[2]), 32'h1);
        acc(1, dxf_pkg::ADDR_SELECT_INDEX, 2, 1);
        check("index err", 32'(got_e), 32'h1);
        check("index kept", 32'(line_index[2]), 32'h0);
        acc(1, dxf_pkg::ADDR_OPTIONS, 2, 2);
        check("opt err", 32'(got_e), 32'h1);
        check("opt kept", line_options[2], 32'h1);
        acc(1, dxf_pkg::ADDR_SELECT_INDEX, 16, 32'(dxf_pkg::FEAT_HS_COUNTER));
        acc(1, dxf_pkg::ADDR_SETTING_B, 16, 32'h3333);
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 16, 1);
        check("latched b", sb[16], 32'h3333);
        acc(1, dxf_pkg::ADDR_SETTING_B, 16, 32'h4444);
        check("held b", sb[16], 32'h3333);
        $display("t_latch done");
    endtask
    task automatic t_codes();
        for (int i = 0; i <= 12; i++) begin
            acc(1, dxf_pkg::ADDR_SELECT_INDEX, 0, 32'(i));
            check("index code", 32'(line_index[0]), 32'(i));
            check("code ok", 32'(got_e), 32'h0);
        end
        acc(1, dxf_pkg::ADDR_SELECT_INDEX, 0, 32'hD);
        check("code 13 err", 32'(got_e), 32'h1);
        acc(1, dxf_pkg::ADDR_SELECT_INDEX, 4, 32'(dxf_pkg::FEAT_INT_COUNTER));
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 4, 1);
        check("incapable err", 32'(got_e), 32'h1);
        check("incapable off", 32'(line_run[4]), 32'h0);
        acc(1, dxf_pkg::ADDR_SELECT_INDEX, 0, 32'(dxf_pkg::FEAT_QUADRATURE));
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 0, 1);
        acc(1, dxf_pkg::ADDR_SELECT_INDEX, 1, 32'(dxf_pkg::FEAT_INT_COUNTER));
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 1, 1);
        check("claimed err", 32'(got_e), 32'h1);
        check("claimed off", 32'(line_run[1]), 32'h0);
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 0, 0);
        check("stop", 32'(line_run[0]), 32'h0);
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 1, 1);
        acc(1, dxf_pkg::ADDR_RUN_SWITCH, 0, 1);
        check("partner err", 32'(got_e), 32'h1);
        $display("t_codes done");
    endtask
    task automatic t_results();
        @(posedge clk);
        stream_mode <= 1'b1;
        acc(0, dxf_pkg::ADDR_INT_RESULT_A, 16, 0);
        check("stream low", got_d, {16'h0, snap_a[16][15:0]});
        check("capture", 32'(capture_hi), 32'(snap_a[16][31:16]));
        acc(0, dxf_pkg::ADDR_REAL_RESULT_A, 16, 0);
        check("stream real err", 32'(got_e), 32'h1);
        acc(0, dxf_pkg::ADDR_INT_RESULT_A, 2, 0);
        check("stream pwm err", 32'(got_e), 32'h1);
        @(posedge clk);
        stream_mode <= 1'b0;
        acc(0, dxf_pkg::ADDR_INT_RESULT_B, 16, 0);
        check("int b", got_d, 32'hB000_0010);
        acc(0, dxf_pkg::ADDR_REAL_RESULT_B, 16, 0);
        check("real b", got_d, 32'h4100_0010);
        acc(0, dxf_pkg::ADDR_REAL_RESULT_A, 16, 0);
        check("real a", got_d, snap_r[16]);
        acc(0, dxf_pkg::ADDR_INT_RESULT_A_CLEAR, 16, 0);
        check("clear value", got_d, snap_a[16]);
        check("clear pulse", 32'(got_r[16]), 32'h1);
        acc(0, dxf_pkg::ADDR_INT_RESULT_A, 16, 0);
        check("count cleared", 32'(got_d < 32'h8), 32'h1);
        acc(0, dxf_pkg::ADDR_REAL_RESULT_A_CLEAR, 16, 0);
        check("real clear", got_d, snap_r[16]);
        check("real pulse", 32'(got_r[16]), 32'h1);
        acc(0, dxf_pkg::ADDR_INT_RESULT_A_CLEAR, 17, 0);
        check("idle read ok", 32'(got_e), 32'h0);
        check("idle no pulse", 32'(got_r[17]), 32'h0);
        $display("t_results done");
    endtask
    // ------------
    // clock, sequence and watchdog
    // ------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        reset_n = 1'b0;
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0000_0000;
        stream_mode = 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_latch();
        t_codes();
        t_results();
        conclude();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule
